// ==== core/smd_bus_claim.sv ====
// module: claim and broadcast decisions on the internal bus
module smd_bus_claim
   import smd_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       ibValid,
   input  wire smd_org_t   ibOrigin,
   input  wire logic       northHit,
   input  wire logic       southRangeHit,
   input  wire logic       subtractiveMode,
   input  wire logic       extClaimed,
   output logic            northClaim,
   output logic            southClaim,
   output logic            extBroadcast
);
   logic nxt_south;                               // south claim decision
   // subtractive mode takes whatever nobody else claims
   always_comb begin
      nxt_south = southRangeHit;
      if (subtractiveMode)
         nxt_south = southRangeHit || (!extClaimed && !northHit);
   end
   ////////////////////////////////////////////////////////////////////////
   // one-cycle claim pulses the edge after the cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         northClaim   <= 1'b0;
         southClaim   <= 1'b0;
         extBroadcast <= 1'b0;
      end else begin
         northClaim   <= ibValid && ibOrigin != ORG_NORTH && northHit;
         southClaim   <= ibValid && ibOrigin != ORG_SOUTH && nxt_south;
         extBroadcast <= ibValid && ibOrigin != ORG_EXT;
      end
   end
endmodule : smd_bus_claim

// ==== core/smd_cfg_if.sv ====
// interface: configuration state from register file to decoder
interface smd_cfg_if;
   import smd_pkg::*;
   smd_cfg_t cfg;                                 // current configuration
   modport src  (output cfg);
   modport sink (input  cfg);
endinterface : smd_cfg_if

// ==== core/smd_cfg_regs.sv ====
// module: config space registers of the address decoder
module smd_cfg_regs
   import smd_pkg::*;
#(
   parameter logic [7:0] TOM_RST    = 8'h07,
   parameter logic [7:0] ROM_EN_RST = 8'h00
) (
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       cfgWrEn,
   input  wire logic       cfgRdEn,
   input  wire logic [7:0] cfgAddr,
   input  wire logic [7:0] cfgWrData,
   output logic      [7:0] cfgRdData,
   smd_cfg_if.src          cfgBus
);
   logic [2*NSEG-1:0] attr_ff;                    // segment attributes
   logic [7:0]        tom_ff;                     // top of main memory
   logic              hole_ff;                    // fixed hole control
   logic [6:0]        romEn_ff;                   // writable boot enables
   logic [7:0]        nxt_rd;                     // read mux
   ////////////////////////////////////////////////////////////////////////
   // writes; all segments disabled after reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         attr_ff  <= '0;
         tom_ff   <= TOM_RST;
         hole_ff  <= 1'b0;
         romEn_ff <= ROM_EN_RST[6:0];
      end else if (cfgWrEn) begin
         if (cfgAddr == CFG_HOLE)
            hole_ff <= cfgWrData[0];
         if (cfgAddr == CFG_TOM)
            tom_ff <= cfgWrData;
         if (cfgAddr == CFG_ROMEN)
            romEn_ff <= cfgWrData[6:0];
         for (int b = 0; b < NATTR_B; b++) begin
            if (cfgAddr == CFG_ATTR + 8'(b)) begin
               attr_ff[4*b +: 2] <= cfgWrData[1:0];
               if (2*b + 1 < NSEG)
                  attr_ff[4*b + 2 +: 2] <= cfgWrData[ATTR_HI +: 2];
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // read mux, unmapped offsets read zero
   always_comb begin
      nxt_rd = 8'h00;
      if (cfgAddr == CFG_HOLE)
         nxt_rd = {7'h00, hole_ff};
      if (cfgAddr == CFG_TOM)
         nxt_rd = tom_ff;
      if (cfgAddr == CFG_ROMEN)
         nxt_rd = {1'b1, romEn_ff};
      for (int b = 0; b < NATTR_B; b++) begin
         if (cfgAddr == CFG_ATTR + 8'(b)) begin
            nxt_rd[1:0] = attr_ff[4*b +: 2];
            if (2*b + 1 < NSEG)
               nxt_rd[ATTR_HI +: 2] = attr_ff[4*b + 2 +: 2];
         end
      end
   end
   // read data register, updated on a read strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         cfgRdData <= 8'h00;
      else if (cfgRdEn)
         cfgRdData <= nxt_rd;
   end
   // configuration seen by the decoder
   assign cfgBus.cfg = '{attr: attr_ff, top_of_main_memory: tom_ff, hole: hole_ff,
                         romEn: ROMEN_TOP | {1'b0, romEn_ff}};
endmodule : smd_cfg_regs

// ==== core/smd_decoder.sv ====
// module: system memory address decoder top with config and claim logic
module smd_decoder
   import smd_pkg::*;
#(
   parameter logic [7:0]  TOM_RST    = 8'h07,   // top of memory reset, MB-1
   parameter logic [7:0]  ROM_EN_RST = 8'h00,   // boot enables reset
   parameter int unsigned ADDR_W     = 32       // host address width
) (
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   // config space port
   input  wire logic              cfgWrEn,
   input  wire logic              cfgRdEn,
   input  wire logic [7:0]        cfgAddr,
   input  wire logic [7:0]        cfgWrData,
   output logic      [7:0]        cfgRdData,
   // cycle from host bus or pci bus 0
   input  wire logic              cycValid,
   input  wire logic              cycSrcPci,
   input  wire logic              cycIo,
   input  wire logic              cycWrite,
   input  wire logic [ADDR_W-1:0] cycAddr,
   input  wire logic              mgmtMode,
   // routing answer
   output logic                   routeValid,
   output smd_tgt_t               routeTarget,
   output logic                   routeWrite,
   output logic                   routeIsIo,
   output logic                   routeIoOk,
   // internal bus cycle
   input  wire logic              ibValid,
   input  wire smd_org_t          ibOrigin,
   input  wire logic              ibWrite,
   input  wire logic [ADDR_W-1:0] ibAddr,
   input  wire logic              southRangeHit,
   input  wire logic              subtractiveMode,
   input  wire logic              extClaimed,
   output logic                   northClaim,
   output logic                   southClaim,
   output logic                   extBroadcast
);
   ////////////////////////////////////////////////////////////////////////
   // elaboration checks
   generate
      if (ADDR_W != AW) begin : g_bad_aw
         $error("smd_decoder: address width must be 32");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // declarations
   smd_cfg_if cfgLink ();                        // config state carrier
   smd_cfg_t  cfg;                               // local copy of config
   logic      hostMm;                            // management mode applies
   smd_tgt_t  hostTgt;                           // target of bus cycle
   smd_tgt_t  ibTgt;                             // target of internal cycle
   logic      ioInReach;                         // io address in reach
   smd_tgt_t  nxt_target;                        // next answer target
   logic      nxt_valid;                         // next answer strobe
   logic      northHit;                          // internal cycle is ours

   ////////////////////////////////////////////////////////////////////////
   // route one memory address to its target
   function automatic smd_tgt_t routeOf(
      input logic [31:0] a,
      input logic        wr,
      input logic        mm,
      input smd_cfg_t    c
   );
      logic [5:0] seg;                           // attribute segment
      logic [1:0] at;                            // its read/write bits
      logic       en;                            // enable for direction
      logic [2:0] chunk;                         // boot window chunk
      seg   = a[SEG_MSB:SEG_LSB] - SEG_BASE;
      // f0000-fffff is one 64 KB segment, its four 16 KB slots share it
      if (seg > 6'(NSEG - 1))
         seg = 6'(NSEG - 1);
      at    = c.attr[2*seg +: 2];
      // writes follow the write bit, reads the read bit
      en    = wr ? at[ATTR_WR] : at[ATTR_RD];
      chunk = a[ROM_MSB:ROM_LSB];
      // the full 32-bit address is the whole memory reach
      if (a <= DOS_END)
         routeOf = TGT_MAIN;
      else if (a <= HOLE_END)
         routeOf = c.hole ? TGT_PCI : TGT_MAIN;
      else if (a <= VIDEO_END)
         routeOf = mm ? TGT_MAIN : TGT_PCI;
      else if (a <= EXPN_END)
         routeOf = en ? TGT_MAIN : TGT_PCI;
      else if (a <= BIOS_END)
         routeOf = en ? TGT_MAIN : TGT_ROM;
      else if (a[31:MB_LSB] <= {4'h0, c.top_of_main_memory})
         routeOf = TGT_MAIN;
      else if (a >= APIC_LO && a <= APIC_HI)
         routeOf = TGT_RSVD;
      else if (a < HIBIOS_LO)
         routeOf = TGT_PCI;
      else if (a >= TOPSEG_LO)
         routeOf = TGT_ROM;
      else
         routeOf = c.romEn[chunk] ? TGT_ROM : TGT_PCI;
   endfunction : routeOf

   ////////////////////////////////////////////////////////////////////////
   // config registers
   smd_cfg_regs #(
      .TOM_RST    (TOM_RST),
      .ROM_EN_RST (ROM_EN_RST)
   ) u_regs (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .cfgWrEn    (cfgWrEn),
      .cfgRdEn    (cfgRdEn),
      .cfgAddr    (cfgAddr),
      .cfgWrData  (cfgWrData),
      .cfgRdData  (cfgRdData),
      .cfgBus     (cfgLink.src)
   );

   // configuration used by both decode paths
   assign cfg = cfgLink.cfg;

   ////////////////////////////////////////////////////////////////////////
   // bus cycle decode
   // only the processor may reach management space
   assign hostMm    = mgmtMode && !cycSrcPci;
   assign hostTgt   = routeOf(cycAddr, cycWrite, hostMm, cfg);
   // io space is 64K+3 bytes wide
   assign ioInReach = cycAddr <= IO_LAST;

   // io cycles in reach pass to pci, others have no target
   always_comb begin
      nxt_valid  = cycValid;
      nxt_target = hostTgt;
      if (cycIo) begin
         if (ioInReach)
            nxt_target = TGT_PCI;
         else
            nxt_target = TGT_RSVD;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // answer strobe, one cycle after the cycle is taken
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         routeValid <= 1'b0;
      else
         routeValid <= nxt_valid;
   end

   // answer data, held until the next taken cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         routeTarget <= TGT_RSVD;
         routeWrite  <= 1'b0;
         routeIsIo   <= 1'b0;
         routeIoOk   <= 1'b0;
      end else if (cycValid) begin
         routeTarget <= nxt_target;
         routeWrite  <= cycWrite;
         routeIsIo   <= cycIo;
         routeIoOk   <= cycIo && ioInReach;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // internal bus decode
   // the same map applies to internal cycles, without management mode;
   // north owns main memory and claims only on an address match
   assign ibTgt    = routeOf(ibAddr, ibWrite, 1'b0, cfg);
   assign northHit = ibTgt == TGT_MAIN;

   // claim and broadcast pulses
   smd_bus_claim u_claim (
      .sys_clk         (sys_clk),
      .nrst            (nrst),
      .ibValid         (ibValid),
      .ibOrigin        (ibOrigin),
      .northHit        (northHit),
      .southRangeHit   (southRangeHit),
      .subtractiveMode (subtractiveMode),
      .extClaimed      (extClaimed),
      .northClaim      (northClaim),
      .southClaim      (southClaim),
      .extBroadcast    (extBroadcast)
   );
endmodule : smd_decoder

// ==== core/smd_pkg.sv ====
// package: address map constants and config layout of the decoder
package smd_pkg;
   localparam int unsigned AW      = 32;         // memory address width
   ////////////////////////////////////////////////////////////////////////
   // targets of a memory cycle, one-hot
   typedef enum logic [3:0] {
      TGT_MAIN = 4'h1,                            // main memory
      TGT_PCI  = 4'h2,                            // external pci memory
      TGT_ROM  = 4'h4,                            // boot rom
      TGT_RSVD = 4'h8                             // reserved, no target
   } smd_tgt_t;
   // origin of a cycle seen on the internal bus
   typedef enum logic [1:0] {
      ORG_NORTH = 2'h0,
      ORG_SOUTH = 2'h1,
      ORG_EXT   = 2'h2
   } smd_org_t;
   ////////////////////////////////////////////////////////////////////////
   // fixed range ends
   localparam logic [31:0] DOS_END   = 32'h0007ffff;
   localparam logic [31:0] HOLE_END  = 32'h0009ffff;
   localparam logic [31:0] VIDEO_END = 32'h000bffff;
   localparam logic [31:0] EXPN_END  = 32'h000dffff;
   localparam logic [31:0] BIOS_END  = 32'h000fffff;
   localparam logic [31:0] APIC_LO   = 32'hfec00000;
   localparam logic [31:0] APIC_HI   = 32'hfecfffff;
   localparam logic [31:0] HIBIOS_LO = 32'hffc00000;
   localparam logic [31:0] TOPSEG_LO = 32'hffff0000;
   localparam logic [31:0] IO_LAST   = 32'h00010002;  // 64K+3 bytes
   // 16 KB attribute segments from c0000, the last one is f0000-fffff
   localparam int unsigned SEG_LSB   = 14;
   localparam int unsigned SEG_MSB   = 19;
   localparam logic [5:0]  SEG_BASE  = 6'h30;
   localparam int unsigned NSEG      = 13;
   localparam int unsigned ATTR_RD   = 0;         // read enable bit
   localparam int unsigned ATTR_WR   = 1;         // write enable bit
   localparam int unsigned ATTR_HI   = 4;         // second segment in byte
   localparam int unsigned NATTR_B   = 7;         // attribute bytes
   // boot window chunks of 512 KB
   localparam int unsigned ROM_LSB   = 19;
   localparam int unsigned ROM_MSB   = 21;
   localparam int unsigned MB_LSB    = 20;
   ////////////////////////////////////////////////////////////////////////
   // config space offsets and fixed values
   localparam logic [7:0]  CFG_HOLE  = 8'h56;
   localparam logic [7:0]  CFG_TOM   = 8'h57;
   localparam logic [7:0]  CFG_ATTR  = 8'h59;
   localparam logic [7:0]  CFG_ROMEN = 8'he3;
   localparam logic [7:0]  ROMEN_TOP = 8'h80;     // hardwired top enable
   // decoded configuration carried to the decoder
   typedef struct packed {
      logic [2*NSEG-1:0] attr;                    // read/write per segment
      logic [7:0]        top_of_main_memory;                     // top of memory, MB - 1
      logic              hole;                    // fixed hole control
      logic [7:0]        romEn;                   // boot window enables
   } smd_cfg_t;
endpackage : smd_pkg

// ==== testbench/smd_decoder_checker.sv ====
// checker: timing and fixed-map properties at the decoder's ports
module smd_decoder_checker
   import smd_pkg::*;
#(
   parameter int unsigned ADDR_W = 32   // host address width
) (
   input wire logic              sys_clk,
   input wire logic              nrst,
   input wire logic              cfgRdEn,
   input wire logic [7:0]        cfgAddr,
   input wire logic [7:0]        cfgRdData,
   input wire logic              cycValid,
   input wire logic              cycIo,
   input wire logic [ADDR_W-1:0] cycAddr,
   input wire logic              mgmtMode,
   input wire logic              routeValid,
   input wire smd_tgt_t          routeTarget,
   input wire logic              routeIoOk,
   input wire logic              ibValid,
   input wire smd_org_t          ibOrigin,
   input wire logic              northClaim,
   input wire logic              southClaim,
   input wire logic              extBroadcast
);
   timeunit 1ns;
   timeprecision 1ns;
   // all properties share the one clock and reset
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   // a memory cycle being taken this edge
   wire logic memCyc = cycValid && !cycIo;
   ////////////////////////////////////////////////////////////////////////
   a_route_answer: assert property (cycValid |=> routeValid)
      else $error("taken cycle got no answer");
   a_route_quiet: assert property (!cycValid |=> !routeValid)
      else $error("answer without a cycle");
   a_dos_main: assert property (memCyc && cycAddr <= 32'h7ffff
      |=> routeTarget == TGT_MAIN) else $error("low area not main");
   a_video_pci: assert property (memCyc && !mgmtMode
      && cycAddr inside {[32'ha0000:32'hbffff]} |=> routeTarget == TGT_PCI)
      else $error("video window not pci");
   a_apic_rsvd: assert property (memCyc
      && cycAddr inside {[32'hfec00000:32'hfecfffff]}
      |=> routeTarget == TGT_RSVD) else $error("reserved window routed");
   a_gap_pci: assert property (memCyc && (cycAddr inside
      {[32'h10000000:32'hfebfffff], [32'hfed00000:32'hffbfffff]})
      |=> routeTarget == TGT_PCI) else $error("pci gap not pci");
   a_top_rom: assert property (memCyc && cycAddr >= 32'hffff0000
      |=> routeTarget == TGT_ROM) else $error("top segment not rom");
   a_io_reach: assert property (cycValid && cycIo
      |=> routeIoOk == ($past(cycAddr) <= 32'h10002))
      else $error("io reach flag wrong");
   a_rom_bit: assert property (cfgRdEn && cfgAddr == 8'he3
      |=> cfgRdData[7]) else $error("top enable reads 0");
   a_bcast_out: assert property ((ibValid && ibOrigin != ORG_EXT)
      |=> extBroadcast) else $error("cycle not broadcast");
   a_north_self: assert property (ibValid && ibOrigin == ORG_NORTH
      |=> !northClaim) else $error("north claimed own cycle");
   a_south_self: assert property (ibValid && ibOrigin == ORG_SOUTH
      |=> !southClaim) else $error("south claimed own cycle");
endmodule : smd_decoder_checker

bind smd_decoder smd_decoder_checker #(.ADDR_W(ADDR_W)) i_smd_decoder_checker (
   .sys_clk(sys_clk), .nrst(nrst), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
   .cfgRdData(cfgRdData), .cycValid(cycValid), .cycIo(cycIo),
   .cycAddr(cycAddr), .mgmtMode(mgmtMode), .routeValid(routeValid),
   .routeTarget(routeTarget), .routeIoOk(routeIoOk), .ibValid(ibValid),
   .ibOrigin(ibOrigin), .northClaim(northClaim), .southClaim(southClaim),
   .extBroadcast(extBroadcast));

// ==== testbench/smd_decoder_tb.sv ====
// testbench: routes cycles and bus claims, checks answers from queues
module smd_decoder_tb
   import smd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] S_LO = 32'h20000000, E_LO = 32'h30000000;
   logic sys_clk = 0, nrst = 0, cfgWrEn = 0, cfgRdEn = 0, ibSeen = 0;
   logic cycValid = 0, cycSrcPci = 0, cycIo = 0, cycWrite = 0, mgmtMode = 0;
   logic ibValid = 0, ibWrite = 0, subtractiveMode = 0, hole = 0;
   logic [7:0]  cfgAddr = 0, cfgWrData = 0, cfgRdData, top_of_main_memory = 8'h07;
   logic [7:0]  romEn = 8'h80;       // mirror of the boot enables
   logic [31:0] cycAddr = 0, ibAddr = 0, l, r;
   logic [25:0] attr = 0;            // mirror of segment attributes
   smd_org_t    ibOrigin = ORG_NORTH;
   smd_tgt_t    routeTarget;
   logic routeValid, routeWrite, routeIsIo, routeIoOk, southRangeHit;
   logic northClaim, southClaim, extBroadcast, extClaimed;
   logic [6:0]  rq [$];              // expected route answers
   logic [2:0]  cq [$];              // expected claim pulses
   logic [31:0] fix [7] = '{32'hfec00000, 32'hfecfffff, 32'hfebfffff,
      32'hfed00000, 32'hffbfffff, 32'hffff0000, 32'hffffffff};
   logic [31:0] iba [4] = '{32'h0, S_LO, E_LO, 32'h40000000};
   int err_count = 0, num_checks = 0, s, i, k;
   always #5 sys_clk = ~sys_clk;
   smd_decoder i_smd_decoder (.sys_clk(sys_clk), .nrst(nrst),
      .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
      .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cycValid(cycValid),
      .cycSrcPci(cycSrcPci), .cycIo(cycIo), .cycWrite(cycWrite),
      .cycAddr(cycAddr), .mgmtMode(mgmtMode), .routeValid(routeValid),
      .routeTarget(routeTarget), .routeWrite(routeWrite),
      .routeIsIo(routeIsIo), .routeIoOk(routeIoOk), .ibValid(ibValid),
      .ibOrigin(ibOrigin), .ibWrite(ibWrite), .ibAddr(ibAddr),
      .southRangeHit(southRangeHit), .subtractiveMode(subtractiveMode),
      .extClaimed(extClaimed), .northClaim(northClaim),
      .southClaim(southClaim), .extBroadcast(extBroadcast));
   smd_pci_agents i_smd_pci_agents (.ibAddr(ibAddr),
      .southRangeHit(southRangeHit), .extClaimed(extClaimed));
   ////////////////////////////////////////////////////////////////////////
   // one comparison, counted and reported
   task automatic check(logic [7:0] got, logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // expected target of a cycle, from the mirrored configuration
   function automatic smd_tgt_t ref_tgt(logic [31:0] a, logic wr, mm, io);
      int g;
      g = (a[19:14] > 6'h3c) ? 12 : int'(a[19:14]) - 48;
      if (io) return (a <= 32'h10002) ? TGT_PCI : TGT_RSVD;
      if (a <= 32'h7ffff) return TGT_MAIN;
      if (a <= 32'h9ffff) return hole ? TGT_PCI : TGT_MAIN;
      if (a <= 32'hbffff) return mm ? TGT_MAIN : TGT_PCI;
      if (a <= 32'hfffff) return attr[2*g+int'(wr)] ? TGT_MAIN
         : ((a <= 32'hdffff) ? TGT_PCI : TGT_ROM);
      if (a[31:20] <= {4'h0, top_of_main_memory}) return TGT_MAIN;
      if (a[31:20] == 12'hfec) return TGT_RSVD;
      if (a < 32'hffc00000) return TGT_PCI;
      return (romEn[a[21:19]] || a >= 32'hffff0000) ? TGT_ROM : TGT_PCI;
   endfunction : ref_tgt
   // issue one routed cycle and note its answer
   task automatic route(logic [31:0] a, logic wr, mm, pci, io);
      @(posedge sys_clk);
      cycValid <= 1;
      ibValid <= 0;
      cycAddr <= a;
      cycWrite <= wr;
      mgmtMode <= mm;
      cycSrcPci <= pci;
      cycIo <= io;
      rq.push_back({ref_tgt(a, wr, mm && !pci, io), wr, io,
         io && a <= 32'h10002});
   endtask : route
   // issue one internal bus cycle and note its claims
   task automatic ib(int o, logic [31:0] a, logic sub);
      logic n;
      n = ref_tgt(a, 1'b0, 1'b0, 1'b0) == TGT_MAIN;
      @(posedge sys_clk);
      ibValid <= 1;
      cycValid <= 0;
      ibOrigin <= smd_org_t'(o);
      ibAddr <= a;
      ibWrite <= a[29];
      subtractiveMode <= sub;
      cq.push_back({o != 0 && n, o != 1 && (a[31:28] == 4'h2
         || (sub && a[31:28] != 4'h3 && !n)), o != 2});
   endtask : ib
   // drop both cycle strobes, cycValid and ibValid
   task automatic quiet();
      @(posedge sys_clk);
      cycValid <= 0;
      ibValid <= 0;
   endtask : quiet
   // config write, mirrored for the reference
   task automatic cfg_wr(logic [7:0] a, logic [7:0] d);
      @(posedge sys_clk);
      cfgWrEn <= 1;
      cycValid <= 0;
      ibValid <= 0;
      cfgAddr <= a;
      cfgWrData <= d;
      if (a == 8'h56) hole = d[0];
      if (a == 8'h57) top_of_main_memory = d;
      if (a == 8'he3) romEn = {1'b1, d[6:0]};
      if (a inside {[8'h59:8'h5e]}) attr[4*(a-8'h59) +: 4] = {d[5:4], d[1:0]};
      if (a == 8'h5f) attr[25:24] = d[1:0];   // last byte has one segment
      @(posedge sys_clk);
      cfgWrEn <= 0;
   endtask : cfg_wr
   // config read, masked compare one cycle later
   task automatic cfg_rd(logic [7:0] a, logic [7:0] exp, logic [7:0] m);
      @(posedge sys_clk);
      cfgRdEn <= 1;
      cycValid <= 0;
      ibValid <= 0;
      cfgAddr <= a;
      @(posedge sys_clk);
      cfgRdEn <= 0;
      #1 check(cfgRdData & m, exp);
   endtask : cfg_rd
   // report and end the run
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////
   // monitor: pop the oldest note whenever an answer shows
   always @(posedge sys_clk) begin
      ibSeen <= ibValid && nrst;
      if (routeValid) check({routeTarget, routeWrite, routeIsIo, routeIoOk},
         rq.size() ? rq.pop_front() : 8'hff);
      if (ibSeen) check({northClaim, southClaim, extBroadcast},
         cq.size() ? cq.pop_front() : 8'hff);
   end
   // main sequence
   initial begin
      void'($urandom(32'hcdfd));
      repeat (2) @(posedge sys_clk);
      nrst <= 1;
      cfg_rd(8'he3, 8'h80, 8'hff);
      cfg_rd(8'h57, 8'h07, 8'hff);
      cfg_rd(8'h40, 8'h00, 8'hff);
      route(32'h000f0000, 0, 0, 0, 0);
      route(32'h000fffff, 1, 0, 0, 0);
      route(32'h00080000, 0, 0, 0, 0);
      route(32'h000c0000, 1, 0, 0, 0);
      route(32'h0007ffff, 1, 1, 1, 0);
      for (s = 0; s < 4; s++) begin
         cfg_wr(8'h59, 8'(8'h11 * s));
         cfg_wr(8'h5f, 8'(8'h11 * s));
         cfg_rd(8'h5f, 8'(s), 8'h33);
         for (i = 0; i < 6; i++) route(i < 2 ? 32'hc3fff : i < 4 ? 32'hc4000
            : 32'hf8000, i[0], 0, 0, 0);
         quiet();
      end
      cfg_wr(8'h56, 8'h01);
      route(32'h0009ffff, 0, 0, 0, 0);
      route(32'h000a0000, 0, 1, 0, 0);
      route(32'h000a0000, 1, 1, 1, 0);
      route(32'h000bffff, 0, 0, 0, 0);
      foreach (fix[j]) route(fix[j], j[0], 0, 0, 0);
      route(32'h00010002, 0, 0, 0, 1);
      route(32'h00010003, 1, 0, 0, 1);
      for (s = 0; s < 2; s++) begin
         r = $urandom;
         cfg_wr(8'h57, s ? 8'hff : 8'h0f);
         l = ({24'h0, top_of_main_memory} + 32'h1) << 20;
         route(l - 32'h1, r[0], 0, 0, 0);
         route(l, r[1], 0, 0, 0);
         cfg_wr(8'he3, s ? r[15:8] : 8'h00);
         cfg_rd(8'he3, romEn, 8'hff);
         for (k = 0; k < 8; k++) route(32'hffc00000 + k * 32'h80000
            + r[18:0], r[k], 0, 0, 0);
      end
      repeat (200) begin
         r = $urandom;
         route($urandom, r[0], r[1], r[2], r[5:3] == 3'h0);
      end
      for (k = 0; k < 24; k++) ib(k % 3, iba[k / 6], k[0]);
      quiet();
      for (k = 0; k < 20 && (rq.size() || cq.size()); k++) @(posedge sys_clk);
      if (rq.size() || cq.size()) err_count++;
      tally_and_finish();
   end
endmodule : smd_decoder_tb

// ==== testbench/smd_pci_agents.sv ====
// model: one south positive range and an external pci agent on bus 0
module smd_pci_agents #(
   parameter logic [31:0] SOUTH_LO = 32'h20000000, // south positive range
   parameter logic [31:0] SOUTH_HI = 32'h2fffffff,
   parameter logic [31:0] EXT_LO   = 32'h30000000, // external agent range
   parameter logic [31:0] EXT_HI   = 32'h3fffffff
) (
   input  wire logic [31:0] ibAddr,        // only 32-bit addresses
   output logic             southRangeHit,
   output logic             extClaimed
);
   timeunit 1ns;
   timeprecision 1ns;
   // agents answer at once from the address of the cycle
   assign southRangeHit = ibAddr inside {[SOUTH_LO:SOUTH_HI]};
   assign extClaimed    = ibAddr inside {[EXT_LO:EXT_HI]};
endmodule : smd_pci_agents
